/* bench/apm_axis_model.sv */
// far-side model: supply phases, motor currents, encoder angle, brake
module apm_axis_model (
  // scenario settings
  input  wire logic             [15:0] bus_set,
  input  wire logic             [2:0]  phase_set,
  input  wire logic [2:0]       [15:0] cur_set,
  input  wire logic             [15:0] angle_set,
  // brake release lines from the drive
  input  wire logic                    rel_one,
  input  wire logic                    rel_two,
  // toward the drive
  output apm_pkg::apm_meas_t           meas,
  output logic                  [15:0] elec_angle,
  output logic                         brake_engaged
);
  timeunit 1ns;
  timeprecision 100ps;
  import apm_pkg::*;

  // sensors follow the supply and the motor directly
  assign meas = '{bus_voltage: bus_set, phase_present: phase_set, phase_current: cur_set};
  assign elec_angle         = angle_set;
  // spring brake holds unless a release line is high
  assign brake_engaged      = !(rel_one || rel_two);
endmodule // apm_axis_model

/* bench/test_apm_monitor.sv */
// self-checking bench for the axis protection monitor
module test_apm_monitor;
  timeunit 1ns;
  timeprecision 100ps;
  import apm_pkg::*;

  logic             clk        = 1'b0;
  logic             sys_rst    = 1'b1;
  logic [15:0]      bus_set    = 16'h0bb7;
  logic [2:0]       phase_set  = 3'h7;
  logic [2:0][15:0] cur_set    = '0;
  logic [15:0]      angle_set  = 16'h1234;
  apm_limits_t      lim;
  apm_motor_type_t  motor_type = APM_THREE_PHASE_SYNC_TYPE;
  apm_brake_sel_t   brake_sel  = APM_DRIVE_FIRST_OUTPUT;
  logic [15:0]      hold_delay = 16'h0002;
  logic             permit     = 1'b0;
  logic             dump_sel   = 1'b0;
  logic             stage3     = 1'b0;
  logic             rev        = 1'b0;
  logic [15:0]      pairs      = 16'h0004;
  logic [15:0]      lines      = 16'h0001;
  logic             req        = 1'b0;
  apm_meas_t        meas;
  logic [15:0]      elec_angle;
  logic             engaged;
  logic             stage_en;
  logic             out_one;
  logic             out_two;
  logic             brake_line;
  logic             dump_int;
  logic             dump_ext;
  logic [15:0]      angle;
  logic [15:0]      pairs_used;
  logic [15:0]      lines_used;
  apm_status_t      status;
  logic             ev;
  logic [4:0]       exp_b;
  int               err_count  = 0;
  int               num_checks = 0;
  int               n;

  always #2.5 clk = ~clk;

  apm_axis_model apm_axis_model_inst (.bus_set(bus_set), .phase_set(phase_set),
    .cur_set(cur_set), .angle_set(angle_set), .rel_one(out_one), .rel_two(out_two),
    .meas(meas), .elec_angle(elec_angle), .brake_engaged(engaged));

  apm_monitor apm_monitor_inst (.clk(clk), .sys_rst(sys_rst), .meas(meas),
    .elec_angle(elec_angle), .limits(lim), .motor_type(motor_type),
    .holding_brake_output_select(brake_sel), .brake_engage_delay(hold_delay),
    .reduced_phase_permit(permit), .outboard_dump_resistor_select(dump_sel),
    .three_phase_stage(stage3), .reverse_electrical_sense(rev),
    .magnet_pair_count(pairs), .lines_per_rev(lines), .axis_enable_req(req),
    .power_stage_enable(stage_en), .digital_output_one(out_one),
    .digital_output_two(out_two), .motor_brake_line(brake_line),
    .internal_dump_on(dump_int), .external_dump_on(dump_ext),
    .commutation_angle(angle), .pole_pairs_used(pairs_used), .lines_used(lines_used),
    .status(status),
    .status_event(ev));

  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic fail_wait();
    err_count++;
    results();
  endtask

  // n edges, then settle just after the last one
  task automatic cyc(input int cnt);
    repeat (cnt) @(posedge clk);
    #1;
  endtask

  function automatic logic [2:0][15:0] all3(input logic [15:0] v);
    return {v, v, v};
  endfunction

  // ticks control periods cover sampling plus status update
  task automatic step(input logic [15:0] bv, input logic [2:0] ph,
                      input logic [2:0][15:0] cur, input int ticks, input logic [5:0] exp);
    bus_set = bv;
    phase_set = ph;
    cur_set = cur;
    cyc(2001 * ticks + 1);
    check(16'(status), 16'(exp));
  endtask

  task automatic dump_case(input logic [15:0] bv, input logic st, input logic sel,
                           input logic [1:0] exp);
    bus_set = bv;
    stage3 = st;
    dump_sel = sel;
    cyc(2);
    check(16'({dump_int, dump_ext}), 16'(exp));
  endtask

  initial begin
    lim.bus_voltage_low_limit = 16'h0bb8;
    lim.bus_voltage_high_limit = 16'h0fa0;
    // 707 rms scaled by root two
    lim.current_ceiling = 16'h03e8;
    lim.current_ceiling_alert_ratio = 17'h0_8000;
    lim.continuous_current_rating = 16'h003c;
    lim.continuous_alert_ratio = RATIO_ONE;
    lim.thermal_time_constant = 5'h03;
    cyc(5);
    sys_rst = 1'b0;
    for (n = 0; n < 2100 && ev !== 1'b1; n++) cyc(1);
    if (n == 2100) fail_wait();
    check(16'(status), 16'h0020);
    cyc(1);
    check(16'(ev), 16'h0000);
    step(16'h0dac, 3'h7, all3(16'h0064), 1, 6'h00);
    step(16'h0dac, 3'h7, all3(16'h0064), 7, 6'h02);
    lim.thermal_time_constant = 5'h00;
    lim.continuous_alert_ratio = 17'h0_8000;
    step(16'h0dac, 3'h7, all3(16'h0000), 2, 6'h00);
    step(16'h0bb8, 3'h7, all3(16'h0000), 1, 6'h00);
    step(16'h0fa1, 3'h7, all3(16'h0000), 1, 6'h20);
    step(16'h0fa0, 3'h3, all3(16'h0000), 1, 6'h10);
    permit = 1'b1;
    step(16'h0fa0, 3'h1, all3(16'h0000), 1, 6'h00);
    step(16'h0fa0, 3'h0, all3(16'h0000), 1, 6'h10);
    step(16'h0dac, 3'h7, all3(16'h0028), 2, 6'h01);
    step(16'h0dac, 3'h7, all3(16'h001e), 2, 6'h00);
    step(16'h0dac, 3'h7, all3(16'h01f4), 2, 6'h03);
    step(16'h0dac, 3'h7, all3(16'hfda8), 2, 6'h07);
    step(16'h0dac, 3'h7, all3(16'h03e9), 2, 6'h0f);
    lim.current_ceiling_alert_ratio = RATIO_ONE;
    lim.continuous_alert_ratio = RATIO_ONE;
    step(16'h0dac, 3'h7, all3(16'h0258), 2, 6'h02);
    motor_type = APM_DC_TYPE;
    pairs = 16'h0001;
    step(16'h0dac, 3'h7, {16'h07d0, 16'h0000, 16'h0000}, 2, 6'h00);
    check(pairs_used, 16'h0001);
    motor_type = APM_TWO_PHASE_SYNC_TYPE;
    pairs = 16'h00c8 / 16'h0004;
    step(16'h0dac, 3'h7, {16'h07d0, 16'h0000, 16'h0000}, 2, 6'h00);
    step(16'h0dac, 3'h7, {16'h0000, 16'h07d0, 16'h0000}, 2, 6'h0a);
    check(pairs_used, 16'h0032);
    motor_type = APM_THREE_PHASE_SYNC_TYPE;
    lines = (16'h7d00 + 16'h000a) / 16'h0014;
    dump_case(16'h0f3d, 1'b1, 1'b0, 2'h2);
    dump_case(16'h0f3d, 1'b1, 1'b1, 2'h1);
    dump_case(16'h0f3c, 1'b1, 1'b1, 2'h0);
    dump_case(16'h0f3d, 1'b0, 1'b0, 2'h0);
    dump_case(16'h0fa1, 1'b0, 1'b0, 2'h2);
    check(lines_used, 16'h0640);
    lines = 16'h0001;
    check(angle, 16'h1234);
    rev = 1'b1;
    cyc(2);
    check(angle, 16'hedcc);
    check(lines_used, 16'h0001);
    for (int s = 0; s < 3; s++) begin
      brake_sel = apm_brake_sel_t'(s);
      exp_b = {1'b1, s == 1, s == 1, s == 2, s == 0};
      req = 1'b1;
      cyc(2);
      check(16'({stage_en, out_one, brake_line, out_two, engaged}), 16'(exp_b));
      req = 1'b0;
      cyc(1);
      check(16'({stage_en, out_one, out_two, brake_line}), 16'h0008);
      cyc(1998);
      check(16'(stage_en), 16'h0001);
      for (n = 0; n < 2300 && stage_en !== 1'b0; n++) cyc(1);
      if (n == 2300) fail_wait();
    end
    brake_sel = APM_DRIVE_FIRST_OUTPUT;
    req = 1'b1;
    cyc(2);
    req = 1'b0;
    cyc(10);
    req = 1'b1;
    cyc(1);
    check(16'({stage_en, out_one}), 16'h0003);
    hold_delay = 16'h0000;
    req = 1'b0;
    cyc(1);
    check(16'({stage_en, out_one}), 16'h0000);
    results();
  end
endmodule // test_apm_monitor

/* common/apm_pkg.sv */
// shared types and constants for the axis protection monitor
package apm_pkg;

  // clock and control-cycle timing
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned CTRL_PERIOD_NS = 10_000;
  localparam int unsigned CTRL_DIV       = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned CTRL_DIV_W     = $clog2(CTRL_DIV);

  // measurement widths and scaling (voltage lsb is 0.1 V)
  localparam int unsigned VAL_W           = 16;
  localparam int unsigned RATIO_W         = 17;
  localparam int unsigned TAU_W           = 5;
  localparam int unsigned VOLT_LSB_PER_V  = 10;
  localparam int unsigned DUMP_OFFSET_V   = 10;
  localparam logic [15:0] DUMP_OFFSET_CNT = 16'(DUMP_OFFSET_V * VOLT_LSB_PER_V);

  // ratio in 1.16 fixed point; exactly one switches the alert off
  localparam logic [16:0] RATIO_ONE = 17'h1_0000;

  // values after reset
  localparam logic [15:0] HOLD_CNT_RST = 16'h0000;
  localparam logic [47:0] ACC_RST      = 48'h0000_0000_0000;

  typedef enum logic [1:0] {
    APM_THREE_PHASE_SYNC_TYPE,
    APM_DC_TYPE,
    APM_TWO_PHASE_SYNC_TYPE
  } apm_motor_type_t;

  typedef enum logic [1:0] {
    APM_BRAKE_NONE,
    APM_DRIVE_FIRST_OUTPUT,
    APM_DRIVE_SECOND_OUTPUT
  } apm_brake_sel_t;

  typedef struct packed {
    logic [15:0]      bus_voltage;
    logic [2:0]       phase_present;
    logic [2:0][15:0] phase_current;
  } apm_meas_t;

  typedef struct packed {
    logic [15:0] bus_voltage_low_limit;
    logic [15:0] bus_voltage_high_limit;
    logic [15:0] current_ceiling;
    logic [16:0] current_ceiling_alert_ratio;
    logic [15:0] continuous_current_rating;
    logic [16:0] continuous_alert_ratio;
    logic [4:0]  thermal_time_constant;
  } apm_limits_t;

  typedef struct packed {
    logic bus_voltage_range_fault;
    logic supply_phase_fault;
    logic current_ceiling_fault;
    logic current_ceiling_alert;
    logic thermal_overload_fault;
    logic continuous_alert;
  } apm_status_t;

endpackage

/* core/apm_i2t_filter.sv */
// first-order averaging of one phase current squared
module apm_i2t_filter (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // control cycle
  input  wire logic        tick,
  input  wire logic [15:0] current,
  input  wire logic [4:0]  tau_shift,
  // averaged square, integer part
  output logic      [31:0] sq_avg
);
  import apm_pkg::*;

  logic [47:0] acc_r;
  logic [47:0] acc_nxt;
  logic [15:0] mag;
  logic [47:0] sq_ext;
  logic [31:0] sq;
  logic [47:0] step_up;
  logic [47:0] step_dn;

  assign mag     = current[15] ? 16'(-current) : current;
  // widen before squaring, braces keep only 16 bits
  assign sq      = 32'(mag) * 32'(mag);
  assign sq_ext  = {sq, 16'h0000};
  assign step_up = (sq_ext - acc_r) >> tau_shift;
  assign step_dn = (acc_r - sq_ext) >> tau_shift;
  // acc moves 1/2^tau of the way toward the new square
  assign acc_nxt = (sq_ext >= acc_r) ? acc_r + step_up : acc_r - step_dn;
  assign sq_avg  = acc_r[47:16];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_r <= ACC_RST;
    end else if (tick) begin
      acc_r <= acc_nxt;
    end
  end
endmodule // apm_i2t_filter

/* core/apm_monitor.sv */
// axis supervision: bus voltage, supply, current and brake sequencing
// How it works
// RULE1: bus voltage outside window raises fault
// RULE2: three-phase variant dumps ten volts below limit
// RULE3: permit false needs all three phases
// RULE4: select routes braking energy internal or external
// RULE5: brake output released while axis enabled
// RULE6: first output drives output one and connector
// RULE7: second output drives output two
// RULE8: stage stays enabled for brake delay
// RULE9: reverse sense inverts commutation angle
// RULE10: current above ceiling raises fault
// RULE11: ratio times ceiling warns; one disables
// RULE12: averaged phase current above rating faults
// RULE13: ratio times rating warns; one disables
// RULE14: time constant sets i2t averaging
// RULE15: host picks motor type by motor
// RULE16: host sets pair count one linear/dc
// RULE17: stepper pair count is steps over four
// RULE18: digital absolute encoder uses one line
// RULE19: linear lines is pitch ratio rounded
// RULE20: host scales rms ceiling by root two
// RULE21: host sets current limits before enabling
// RULE22: checks run each control cycle, report events
module apm_monitor (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // measurements
  input  wire apm_pkg::apm_meas_t       meas,
  input  wire logic [15:0]              elec_angle,
  // configuration
  input  wire apm_pkg::apm_limits_t     limits,
  input  wire apm_pkg::apm_motor_type_t motor_type,
  input  wire apm_pkg::apm_brake_sel_t  holding_brake_output_select,
  input  wire logic [15:0]              brake_engage_delay,
  input  wire logic                     reduced_phase_permit,
  input  wire logic                     outboard_dump_resistor_select,
  input  wire logic                     three_phase_stage,
  input  wire logic                     reverse_electrical_sense,
  input  wire logic [15:0]              magnet_pair_count,
  input  wire logic [15:0]              lines_per_rev,
  // axis control
  input  wire logic                     axis_enable_req,
  // outputs to the power stage and pins
  output logic                          power_stage_enable,
  output logic                          digital_output_one,
  output logic                          digital_output_two,
  output logic                          motor_brake_line,
  output logic                          internal_dump_on,
  output logic                          external_dump_on,
  output logic [15:0]                   commutation_angle,
  output logic [15:0]                   pole_pairs_used,
  output logic [15:0]                   lines_used,
  // status to software
  output apm_pkg::apm_status_t          status,
  output logic                          status_event
);
  import apm_pkg::*;

  typedef enum logic [1:0] {APM_OFF, APM_ON, APM_HOLD} apm_axis_state_t;

  function automatic logic [15:0] apm_abs(input logic [15:0] v);
    apm_abs = v[15] ? 16'(-v) : v;
  endfunction

  // true when value exceeds ratio*base and ratio is not one, ratio in 1.16
  function automatic logic apm_over_ratio(input logic [15:0] v, input logic [16:0] ratio,
                                          input logic [15:0] base);
    logic [32:0] lhs;
    logic [32:0] rhs;
    lhs = {1'b0, v, 16'h0000};
    rhs = 33'(ratio * base);
    apm_over_ratio = (ratio != RATIO_ONE) && (lhs > rhs);
  endfunction

  function automatic logic [2:0] apm_phase_mask(input apm_motor_type_t t);
    case (t)
      APM_DC_TYPE:             apm_phase_mask = 3'b001;
      APM_TWO_PHASE_SYNC_TYPE: apm_phase_mask = 3'b011;
      default:                 apm_phase_mask = 3'b111;
    endcase
  endfunction

  // control-cycle divider
  logic [CTRL_DIV_W-1:0] div_r;
  logic                  tick;
  assign tick = (div_r == CTRL_DIV_W'(CTRL_DIV - 1));
  always_ff @(posedge clk) begin
    if (sys_rst) div_r <= '0;
    else         div_r <= tick ? '0 : div_r + 1'b1;
  end

  // bus voltage and supply
  wire [15:0] dump_threshold;
  wire        bus_out_of_window;
  wire        phase_bad;
  wire        dump_needed;
  // RULE1: window compare
  assign bus_out_of_window = (meas.bus_voltage < limits.bus_voltage_low_limit) ||
                             (meas.bus_voltage > limits.bus_voltage_high_limit);
  // RULE2: dump threshold offset
  assign dump_threshold = three_phase_stage ?
                          limits.bus_voltage_high_limit - DUMP_OFFSET_CNT :
                          limits.bus_voltage_high_limit;
  assign dump_needed    = meas.bus_voltage > dump_threshold;
  // RULE3: phase demand
  assign phase_bad = reduced_phase_permit ? (meas.phase_present == 3'b000) :
                                            (meas.phase_present != 3'b111);

  // current checks per phase
  wire [2:0]        mask;
  wire [2:0]        ceil_over;
  wire [2:0]        ceil_warn;
  wire [2:0]        i2t_over;
  wire [2:0]        i2t_warn;
  wire [2:0][31:0]  sq_avg;
  wire [15:0]       cont_warn_level;
  wire [32:0]       cont_warn_prod;
  wire [31:0]       nom_sq;
  wire [31:0]       warn_sq;

  assign mask            = apm_phase_mask(motor_type);
  assign nom_sq          = limits.continuous_current_rating * limits.continuous_current_rating;
  assign cont_warn_prod  = 33'(limits.continuous_alert_ratio * limits.continuous_current_rating);
  assign cont_warn_level = cont_warn_prod[31:16];
  assign warn_sq         = cont_warn_level * cont_warn_level;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    wire [15:0] mag;
    assign mag = apm_abs(meas.phase_current[p]);
    // RULE10: ceiling compare
    assign ceil_over[p] = mask[p] && (mag > limits.current_ceiling);
    // RULE11: ceiling alert
    assign ceil_warn[p] = mask[p] &&
                          apm_over_ratio(mag, limits.current_ceiling_alert_ratio,
                                         limits.current_ceiling);
    // RULE14: averaging with time constant
    apm_i2t_filter u_i2t (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .tick      (tick),
      .current   (meas.phase_current[p]),
      .tau_shift (limits.thermal_time_constant),
      .sq_avg    (sq_avg[p])
    );
    // RULE12: averaged over rating
    assign i2t_over[p] = mask[p] && (sq_avg[p] > nom_sq);
    // RULE13: averaged alert, ratio one disables
    assign i2t_warn[p] = mask[p] && (limits.continuous_alert_ratio != RATIO_ONE) &&
                         (sq_avg[p] > warn_sq);
  end

  // status register, sampled once per control cycle
  apm_status_t status_r;
  apm_status_t status_nxt;
  logic        event_r;
  assign status_nxt = '{bus_voltage_range_fault: bus_out_of_window,
                        supply_phase_fault:      phase_bad,
                        current_ceiling_fault:   |ceil_over,
                        current_ceiling_alert:   |ceil_warn,
                        thermal_overload_fault:  |i2t_over,
                        continuous_alert:        |i2t_warn};
  // RULE22: per-cycle evaluation and event
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_r <= '0;
      event_r  <= 1'b0;
    end else begin
      event_r <= tick && ((status_nxt & ~status_r) != '0);
      if (tick) status_r <= status_nxt;
    end
  end
  assign status       = status_r;
  assign status_event = event_r;

  // axis enable and brake sequencing
  apm_axis_state_t st_r;
  apm_axis_state_t st_nxt;
  logic [15:0]     hold_r;
  logic [15:0]     hold_nxt;
  always_comb begin
    st_nxt   = st_r;
    hold_nxt = hold_r;
    case (st_r)
      APM_OFF: begin
        if (axis_enable_req) st_nxt = APM_ON;
      end
      APM_ON: begin
        if (!axis_enable_req) begin
          hold_nxt = brake_engage_delay;
          st_nxt   = (brake_engage_delay == HOLD_CNT_RST) ? APM_OFF : APM_HOLD;
        end
      end
      APM_HOLD: begin
        // RULE8: hold count in control cycles
        if (axis_enable_req) begin
          st_nxt = APM_ON;
        end else if (tick) begin
          hold_nxt = hold_r - 16'h0001;
          if (hold_r == 16'h0001) st_nxt = APM_OFF;
        end
      end
      default: st_nxt = APM_OFF;
    endcase
  end

  logic stage_r;
  wire  release_nxt;
  // RULE5: release only while on
  assign release_nxt = (st_nxt == APM_ON);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r      <= APM_OFF;
      hold_r    <= HOLD_CNT_RST;
      stage_r   <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      hold_r    <= hold_nxt;
      stage_r   <= (st_nxt != APM_OFF);
    end
  end

  logic out1_r;
  logic out2_r;
  logic int_dump_r;
  logic ext_dump_r;
  logic [15:0] angle_r;
  logic [15:0] pairs_r;
  logic [15:0] lines_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out1_r     <= 1'b0;
      out2_r     <= 1'b0;
      int_dump_r <= 1'b0;
      ext_dump_r <= 1'b0;
      angle_r    <= 16'h0000;
      pairs_r    <= 16'h0000;
      lines_r    <= 16'h0000;
    end else begin
      // RULE6: first output choice
      out1_r     <= release_nxt &&
                    (holding_brake_output_select == APM_DRIVE_FIRST_OUTPUT);
      // RULE7: second output choice
      out2_r     <= release_nxt &&
                    (holding_brake_output_select == APM_DRIVE_SECOND_OUTPUT);
      // RULE4: dump resistor routing
      int_dump_r <= dump_needed && !outboard_dump_resistor_select;
      ext_dump_r <= dump_needed && outboard_dump_resistor_select;
      // RULE9: commutation inversion
      angle_r    <= reverse_electrical_sense ? 16'(-elec_angle) : elec_angle;
      pairs_r    <= magnet_pair_count;
      lines_r    <= lines_per_rev;
    end
  end

  assign power_stage_enable = stage_r;
  assign digital_output_one = out1_r;
  assign motor_brake_line   = out1_r;
  assign digital_output_two = out2_r;
  assign internal_dump_on   = int_dump_r;
  assign external_dump_on   = ext_dump_r;
  assign commutation_angle  = angle_r;
  assign pole_pairs_used    = pairs_r;
  assign lines_used         = lines_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_bus_window_fault: assert property (tick && bus_out_of_window |=> // RULE1
    status.bus_voltage_range_fault) else $error("bus window fault missed");
  a_dump_offset: assert property (three_phase_stage && !outboard_dump_resistor_select && // RULE2
    meas.bus_voltage > limits.bus_voltage_high_limit - DUMP_OFFSET_CNT |=> internal_dump_on)
    else $error("dump not at ten volts below limit");
  a_phase_demand: assert property (tick && !reduced_phase_permit && // RULE3
    meas.phase_present != 3'b111 |=> status.supply_phase_fault) else $error("phase loss missed");
  a_dump_exclusive: assert property (!(internal_dump_on && external_dump_on)) // RULE4
    else $error("both dump resistors on");
  a_release_enabled: assert property (digital_output_one || digital_output_two |-> // RULE5
    power_stage_enable) else $error("brake released while stage off");
  a_first_output: assert property (digital_output_one == motor_brake_line && // RULE6
    !(digital_output_one && digital_output_two)) else $error("first output pairing wrong");
  a_second_output: assert property (axis_enable_req && // RULE7
    holding_brake_output_select == APM_DRIVE_SECOND_OUTPUT ##1 axis_enable_req |->
    digital_output_two) else $error("second output not driven");
  a_hold_stage: assert property ($fell(digital_output_one) && !axis_enable_req && // RULE8
    brake_engage_delay != 16'h0000 |-> power_stage_enable) else $error("stage dropped early");
  a_reverse_sense: assert property (reverse_electrical_sense |=> // RULE9
    commutation_angle == 16'(-$past(elec_angle))) else $error("angle not inverted");
  a_ceiling_fault: assert property (tick && |ceil_over |=> // RULE10
    status.current_ceiling_fault) else $error("ceiling fault missed");
  a_ceiling_alert_off: assert property (limits.current_ceiling_alert_ratio == RATIO_ONE // RULE11
    |-> ceil_warn == 3'b000) else $error("ceiling alert not disabled");
  a_i2t_fault: assert property (tick && |i2t_over |=> // RULE12
    status.thermal_overload_fault) else $error("thermal fault missed");
  a_cont_alert_off: assert property (tick && limits.continuous_alert_ratio == RATIO_ONE // RULE13
    |=> !status.continuous_alert) else $error("continuous alert not disabled");
  a_event_on_rise: assert property (tick && (status_nxt & ~status) != '0 |=> // RULE22
    status_event) else $error("status event missed");

  c_hold_done: cover property ($fell(power_stage_enable) && !$past(digital_output_one));
  c_range_fault: cover property ($rose(status.bus_voltage_range_fault));
  c_thermal: cover property ($rose(status.thermal_overload_fault));
  c_second_brake: cover property ($rose(digital_output_two));
endmodule // apm_monitor
